// [bench/dcap_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcap_params.svh"

module dcap_chk (
   // Clock and reset
   input wire logic                    mclk,
   input wire logic                    rst,
   // Port signals
   input wire logic [`DCAP_ADDR_W-1:0] addr,
   input wire logic [`DCAP_DATA_W-1:0] cfg_port_wdata,
   input wire logic                    en,
   input wire logic                    we,
   input wire logic [`DCAP_DATA_W-1:0] rdata,
   input wire logic                    rdy
);
   // One clock domain, so clock and reset are set once
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Port timing
   // Core takes en one edge after it is seen, then counts two more
   a_rdy_after_en: assert property (en |-> ##3 rdy)
      else $error("completion missing after request");
   a_rdy_needs_en: assert property (rdy |-> $past(en, 3))
      else $error("completion without a request");
   a_rdy_pulse: assert property (rdy |=> !rdy)
      else $error("completion longer than one cycle");
   a_wr_pulse: assert property (en && we |=> !en && !we)
      else $error("write request held past one cycle");
   a_one_outstanding: assert property (en |=> !en [*4])
      else $error("second request while one is outstanding");
   a_we_with_en: assert property (we |-> en)
      else $error("write enable without access enable");
   // Read data moves only on a completion
   a_rdata_on_rdy: assert property (!$stable(rdata) |-> rdy)
      else $error("read data changed without completion");
   a_wr_keeps_rdata: assert property
      (rdy && $past(we, 3) |-> $stable(rdata))
      else $error("write disturbed read data");
endmodule : dcap_chk

`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic        mclk;
   logic        rst;
   logic        req_valid;
   logic        req_write;
   logic [9:0]  req_addr;
   logic [15:0] req_wdata;
   logic        req_ready;
   logic        rsp_valid;
   logic [15:0] rsp_rdata;
   logic        rsp_timeout;
   logic [15:0] word0;
   int          bad_count = 0;
   int          cmp_count = 0;

   dcap_if cfg_bus ();
   dcap_core i_dcap_core (.mclk(mclk), .rst(rst), .cfg(cfg_bus),
      .cfg_word0(word0));
   dcap_master i_dcap_master (.mclk(mclk), .rst(rst), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_timeout(rsp_timeout), .cfg(cfg_bus));
   dcap_chk i_dcap_chk (.mclk(mclk), .rst(rst), .addr(cfg_bus.addr),
      .cfg_port_wdata(cfg_bus.cfg_port_wdata), .en(cfg_bus.en),
      .we(cfg_bus.we), .rdata(cfg_bus.rdata), .rdy(cfg_bus.rdy));

   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One user access; latency counted from the taking edge
   task automatic xfer(input logic w, input logic [9:0] a,
                       input logic [15:0] d, input logic [15:0] exp);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1 n++;
      end
      req_valid = 1'b1;
      req_write = w;
      req_addr  = a;
      req_wdata = d;
      @(posedge mclk);
      #1 req_valid = 1'b0;
      // Count edges after the taking edge up to the answer
      n = 0;
      while (rsp_valid !== 1'b1 && n < 80) begin
         @(posedge mclk);
         #1 n++;
      end
      chk(16'(n), 16'h0004);
      chk({15'h0000, rsp_timeout}, 16'h0000);
      if (!w) chk(rsp_rdata, exp);
   endtask : xfer

   ////////////////////////////////////////////////////////////////////////
   // Word 0 after reset, then a read, one write and readback
   task automatic t_word0;
      chk(word0, 16'h0000);
      xfer(1'b0, 10'h000, 16'h0000, 16'h0000);
      xfer(1'b1, 10'h000, 16'h1234, 16'h0000);
      chk(word0, 16'h1234);
      xfer(1'b0, 10'h000, 16'h0000, 16'h1234);
   endtask : t_word0

   // Spread of addresses from 001 up to the top end of the space
   task automatic t_walk;
      logic [9:0] tbl [5];
      tbl = '{10'h001, 10'h155, 10'h2AA, 10'h3FE, 10'h3FF};
      foreach (tbl[i]) xfer(1'b1, tbl[i], {6'h00, tbl[i]} ^ 16'hC3A5, 16'h0);
      foreach (tbl[i]) xfer(1'b0, tbl[i], 16'hFFFF, {6'h00, tbl[i]} ^ 16'hC3A5);
      chk(word0, 16'h1234);
   endtask : t_walk

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // Watchdog, far beyond the ninety or so cycles the tests need
   initial begin
      #200000;
      bad_count++;
      test_done();
   end

   // Main sequence
   initial begin
      rst       = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr  = 10'h000;
      req_wdata = 16'h0000;
      repeat (8) @(posedge mclk);
      #1 rst = 1'b0;
      @(posedge mclk);
      #1;
      t_word0();
      t_walk();
      test_done();
   end
endmodule : testbench

`default_nettype wire

// [design/dcap_core.sv]
// Behaviour
// - Core takes 10-bit address, 16-bit write data
// - Read data returned on 16-bit bus
// - Enable low means no access
// - Write enable selects write, else read
// - Master pulses enable for one cycle
// - Ready marks write done or read valid
// - Port runs on the core clock mclk
`timescale 1ns/1ps
`default_nettype none
`include "dcap_params.svh"

module dcap_core #(
   parameter int ADDR_W  = `DCAP_ADDR_W,
   parameter int DATA_W  = `DCAP_DATA_W,
   parameter int LATENCY = `DCAP_LATENCY
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Configuration port
   dcap_if.core      cfg,
   // Core side view of configuration word 0
   output var logic [DATA_W-1:0] cfg_word0
);

   localparam int DEPTH = 1 << ADDR_W;

   initial begin
      if (ADDR_W != `DCAP_ADDR_W || DATA_W != `DCAP_DATA_W)
         $error("dcap_core: port widths are fixed at 10 and 16");
      if (LATENCY < 1 || LATENCY > 15)
         $error("dcap_core: latency must be 1 to 15");
   end

   typedef struct packed {
      logic [DEPTH-1:0][DATA_W-1:0] mem;
      logic                         busy;
      dcap_pkg::dcap_kind_t         kind;
      logic [ADDR_W-1:0]            addr;
      logic [DATA_W-1:0]            wdata;
      logic [3:0]                   cnt;
      logic [DATA_W-1:0]            rdata;
      logic                         rdy;
      logic [DATA_W-1:0]            word0;
   } dcap_core_st_t;

   dcap_core_st_t st_q;
   dcap_core_st_t st_d;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   // Requests during a busy access are dropped; the master waits for rdy
   always_comb begin
      st_d     = st_q;
      st_d.rdy = 1'b0;
      if (!st_q.busy && cfg.en) begin
         st_d.busy  = 1'b1;
         st_d.kind  = cfg.we ? dcap_pkg::DCAP_WRITE
                             : dcap_pkg::DCAP_READ;
         st_d.addr  = cfg.addr;
         st_d.wdata = cfg.cfg_port_wdata;
         st_d.cnt   = 4'(LATENCY - 1);
      end else if (st_q.busy) begin
         if (st_q.cnt != 4'h0) begin
            st_d.cnt = st_q.cnt - 4'h1;
         end else begin
            // Complete: commit write or present read word
            st_d.busy = 1'b0;
            st_d.rdy  = 1'b1;
            if (st_q.kind == dcap_pkg::DCAP_WRITE) begin
               st_d.mem[st_q.addr] = st_q.wdata;
            end else begin
               st_d.rdata = st_q.mem[st_q.addr];
            end
         end
      end
      st_d.word0 = st_d.mem[0];
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; port shares mclk with the rest of the core
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign cfg.rdata = st_q.rdata;
   assign cfg.rdy   = st_q.rdy;
   assign cfg_word0 = st_q.word0;

endmodule : dcap_core

`default_nettype wire

// [design/dcap_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcap_params.svh"

interface dcap_if;
   logic [`DCAP_ADDR_W-1:0] addr;
   logic [`DCAP_DATA_W-1:0] cfg_port_wdata;
   logic                    en;
   logic                    we;
   logic [`DCAP_DATA_W-1:0] rdata;
   logic                    rdy;

   // Configuration master end
   modport master (
      output addr,
      output cfg_port_wdata,
      output en,
      output we,
      input  rdata,
      input  rdy
   );

   // Core end
   modport core (
      input  addr,
      input  cfg_port_wdata,
      input  en,
      input  we,
      output rdata,
      output rdy
   );
endinterface : dcap_if

`default_nettype wire

// [design/dcap_master.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcap_params.svh"

module dcap_master #(
   parameter int ADDR_W  = `DCAP_ADDR_W,
   parameter int DATA_W  = `DCAP_DATA_W,
   parameter int TIMEOUT = `DCAP_TIMEOUT
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // User request
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output var logic               req_ready,
   // User answer
   output var logic               rsp_valid,
   output var logic [DATA_W-1:0]  rsp_rdata,
   output var logic               rsp_timeout,
   // Configuration port
   dcap_if.master                 cfg
);

   initial begin
      if (ADDR_W != `DCAP_ADDR_W || DATA_W != `DCAP_DATA_W)
         $error("dcap_master: port widths are fixed at 10 and 16");
      if (TIMEOUT < 2 || TIMEOUT > 65535)
         $error("dcap_master: timeout must be 2 to 65535");
   end

   typedef struct packed {
      dcap_pkg::dcap_mstate_t st;
      logic [ADDR_W-1:0]      addr;
      logic [DATA_W-1:0]      wdata;
      logic                   en;
      logic                   we;
      logic [15:0]            tmo;
      logic                   rsp_valid;
      logic [DATA_W-1:0]      rsp_rdata;
      logic                   rsp_timeout;
   } dcap_mst_st_t;

   dcap_mst_st_t m_q;
   dcap_mst_st_t m_d;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: one access in flight, enable pulsed one cycle
   always_comb begin
      m_d             = m_q;
      m_d.en          = 1'b0;
      m_d.we          = 1'b0;
      m_d.rsp_valid   = 1'b0;
      m_d.rsp_timeout = 1'b0;
      case (m_q.st)
         dcap_pkg::DCAP_M_IDLE: begin
            if (req_valid) begin
               m_d.st    = dcap_pkg::DCAP_M_WAIT;
               m_d.en    = 1'b1;
               m_d.we    = req_write;
               m_d.addr  = req_addr;
               m_d.wdata = req_wdata;
               m_d.tmo   = 16'(TIMEOUT);
            end
         end
         dcap_pkg::DCAP_M_WAIT: begin
            // Timeout guards a core that never raises rdy
            if (cfg.rdy) begin
               m_d.st        = dcap_pkg::DCAP_M_DONE;
               m_d.rsp_valid = 1'b1;
               m_d.rsp_rdata = cfg.rdata;
            end else if (m_q.tmo == 16'h0001) begin
               m_d.st          = dcap_pkg::DCAP_M_DONE;
               m_d.rsp_valid   = 1'b1;
               m_d.rsp_timeout = 1'b1;
            end else begin
               m_d.tmo = m_q.tmo - 16'h0001;
            end
         end
         dcap_pkg::DCAP_M_DONE: begin
            m_d.st = dcap_pkg::DCAP_M_IDLE;
         end
         default: begin
            m_d.st = dcap_pkg::DCAP_M_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         m_q <= '0;
      end else begin
         m_q <= m_d;
      end
   end

   // Ready is registered state: idle means a request is taken
   logic req_ready_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         req_ready_q <= 1'b0;
      end else begin
         req_ready_q <= (m_d.st == dcap_pkg::DCAP_M_IDLE);
      end
   end

   assign req_ready          = req_ready_q;
   assign rsp_valid          = m_q.rsp_valid;
   assign rsp_rdata          = m_q.rsp_rdata;
   assign rsp_timeout        = m_q.rsp_timeout;
   assign cfg.addr           = m_q.addr;
   assign cfg.cfg_port_wdata = m_q.wdata;
   assign cfg.en             = m_q.en;
   assign cfg.we             = m_q.we;

endmodule : dcap_master

`default_nettype wire

// [design/dcap_params.svh]
`ifndef DCAP_PARAMS_SVH
`define DCAP_PARAMS_SVH

// Port widths
`define DCAP_ADDR_W        10
`define DCAP_DATA_W        16
// Configuration space depth, one word per address
`define DCAP_DEPTH         1024
// Cycles from a taken access to its completion strobe
`define DCAP_LATENCY       2
// Reset value of every configuration word
`define DCAP_WORD_RST      16'h0000
// Default command timeout at the master, in cycles
`define DCAP_TIMEOUT       64

`endif

// [design/dcap_pkg.sv]
package dcap_pkg;

   // Access kind chosen by the write enable
   typedef enum logic {
      DCAP_READ,
      DCAP_WRITE
   } dcap_kind_t;

   // Master sequencer states
   typedef enum logic [1:0] {
      DCAP_M_IDLE,
      DCAP_M_WAIT,
      DCAP_M_DONE
   } dcap_mstate_t;

endpackage : dcap_pkg
